// *** core/plms_pkg.sv ***
// Package with register map, reset values and field helpers for the port latch, mode and bypass block.
package plms_pkg;
  localparam logic [7:0] PLMS_ADDR_P1_LATCH  = 8'h90;
  localparam logic [7:0] PLMS_ADDR_P2_LATCH  = 8'hA0;
  localparam logic [7:0] PLMS_ADDR_P2_DRIVE  = 8'hA6;
  localparam logic [7:0] PLMS_ADDR_P3_LATCH  = 8'hB0;
  localparam logic [7:0] PLMS_ADDR_P0_BYPASS = 8'hD4;
  localparam logic [7:0] PLMS_ADDR_P1_BYPASS = 8'hD5;
  localparam logic [7:0] PLMS_ADDR_P2_BYPASS = 8'hD6;
  localparam logic [7:0] PLMS_ADDR_P1_DRIVE  = 8'hA5;
  localparam logic [7:0] PLMS_ADDR_P1_ANADIG = 8'hF2;
  localparam logic [7:0] PLMS_ADDR_P2_ANADIG = 8'hF3;
  localparam logic [7:0] PLMS_ADDR_P3_ANADIG = 8'hF4;
  localparam logic [7:0] PLMS_RST_LATCH      = 8'hFF;
  localparam logic [7:0] PLMS_RST_BYPASS     = 8'h00;
  localparam logic [7:0] PLMS_RST_DRIVE      = 8'h00;
  localparam logic [7:0] PLMS_RST_ANADIG     = 8'hFF;
  localparam int         PLMS_NPORT          = 3;
  typedef logic [7:0] plms_byte_t;

  // Bit-address decode: the low three bits of a latch bit address give the bit position within the latch byte.
  function automatic logic [2:0] plms_bit_pos(input logic [7:0] baddr);
    plms_bit_pos = baddr[2:0];
  endfunction
endpackage

// *** core/plms_pad_if.sv ***
// Interface carrying one port's pad control between the register core and the pad stage.
`timescale 1ns/1ps
interface plms_pad_if;
  logic [7:0] latch;
  logic [7:0] drive;
  logic [7:0] digital;
  logic [7:0] pin_sync;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] rd_val;
  modport core (output latch, output drive, output digital, input rd_val, input pin_out, input pin_oe);
  modport pad  (input latch, input drive, input digital, output rd_val, output pin_out, output pin_oe,
                input pin_sync);
endinterface

// *** core/plms_pad.sv ***
// Pad stage for one eight-pin port: output enable, drive level and pin read value.
`timescale 1ns/1ps
module plms_pad (
  plms_pad_if.pad p  // Port control and results
);
  import plms_pkg::*;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p.pin_out[i] = p.latch[i];
      // Zero drives low; one drives only when push-pull; analog pins never drive.
      p.pin_oe[i]  = p.digital[i] & (~p.latch[i] | p.drive[i]);
      // Analog pins read back zero, digital pins show the synchronised pin level.
      p.rd_val[i]  = p.digital[i] & p.pin_sync[i];
    end
  end
endmodule

// *** core/plms_top.sv ***
// Port latches, drive and analog selects and crossbar bypass masks reached over the special register bus.
`timescale 1ns/1ps
module plms_top (
  input  wire logic                 clk,         // System clock
  input  wire logic                 rst_n,       // Asynchronous reset, active low
  input  wire logic                 ce,          // Clock enable, freezes state when low
  input  wire logic [7:0]           sfr_addr,    // Byte or bit address
  input  wire logic                 sfr_wr,      // Byte write strobe
  input  wire logic                 sfr_rd,      // Byte read strobe
  input  wire logic                 sfr_rmw,     // Qualifies the read as read-modify-write
  input  wire logic                 sfr_bit,     // Access is single-bit at a bit address
  input  wire logic                 sfr_bit_val, // Bit value for a single-bit write
  input  wire plms_pkg::plms_byte_t sfr_wdata,   // Write data
  output      plms_pkg::plms_byte_t sfr_rdata,   // Read data
  output logic                      sfr_rbit,    // Bit read data
  output logic                      sfr_hit,     // Address decoded by this block
  input  wire logic [23:0]          pin_in,      // Pad levels, ports 1..3
  output logic [23:0]               pin_out,     // Pad output level
  output logic [23:0]               pin_oe,      // Pad output enable, high while driving
  output logic [23:0]               skip_mask    // Bypass masks to crossbar, ports 0..2
);
  import plms_pkg::*;

  plms_byte_t latch_r [PLMS_NPORT];
  plms_byte_t latch_nxt [PLMS_NPORT];
  plms_byte_t drive_r [PLMS_NPORT];
  plms_byte_t drive_nxt [PLMS_NPORT];
  plms_byte_t anadig_r [PLMS_NPORT];
  plms_byte_t anadig_nxt [PLMS_NPORT];
  plms_byte_t bypass_r [PLMS_NPORT];
  plms_byte_t bypass_nxt [PLMS_NPORT];
  // Two flops on the pins keep a metastable level away from the read path; reads see pins two edges late.
  logic [23:0] sync1_r;
  logic [23:0] sync1_nxt;
  logic [23:0] sync2_r;
  logic [23:0] sync2_nxt;
  plms_byte_t  rd_r;
  plms_byte_t  rd_nxt;
  logic        rbit_r;
  logic        rbit_nxt;
  logic        hit_r;
  logic        hit_nxt;
  logic [23:0] out_r;
  logic [23:0] out_nxt;
  logic [23:0] oe_r;
  logic [23:0] oe_nxt;
  logic [23:0] skip_r;
  logic [23:0] skip_nxt;
  logic [23:0] out_c;
  logic [23:0] oe_c;
  plms_byte_t  pinval [PLMS_NPORT];

  plms_pad_if pif [PLMS_NPORT] ();

  // One pad stage per port turns latch, drive and analog select into pad controls.
  genvar g;
  generate
    for (g = 0; g < PLMS_NPORT; g++) begin : gp
      assign pif[g].latch    = latch_r[g];
      assign pif[g].drive    = drive_r[g];
      assign pif[g].digital  = anadig_r[g];
      assign pif[g].pin_sync = sync2_r[g*8 +: 8];
      assign pinval[g]       = pif[g].rd_val;
      assign out_c[g*8 +: 8] = pif[g].pin_out;
      assign oe_c[g*8 +: 8]  = pif[g].pin_oe;
      plms_pad u_pad (.p(pif[g]));
    end
  endgenerate

  // Latch index for a byte or bit address, or -1 when the address is no latch.
  function automatic int latch_idx(input logic [7:0] a, input logic is_bit);
    logic [7:0] base;
    base = is_bit ? {a[7:3], 3'h0} : a;
    if (base == PLMS_ADDR_P1_LATCH) latch_idx = 0;
    else if (base == PLMS_ADDR_P2_LATCH) latch_idx = 1;
    else if (base == PLMS_ADDR_P3_LATCH) latch_idx = 2;
    else latch_idx = -1;
  endfunction

  // Register group: one access per cycle, and a read in the same cycle as a write returns the old value.
  always_comb begin
    int         li;
    logic [2:0] bp;
    li = latch_idx(sfr_addr, sfr_bit);
    bp = plms_bit_pos(sfr_addr);
    // Everything but hit holds unless this cycle's access names it; hit clears each cycle.
    for (int k = 0; k < PLMS_NPORT; k++) begin
      latch_nxt[k]  = latch_r[k];
      drive_nxt[k]  = drive_r[k];
      anadig_nxt[k] = anadig_r[k];
      bypass_nxt[k] = bypass_r[k];
    end
    // Port 3 has no drive select in this block, so its pins stay open drain.
    drive_nxt[2] = PLMS_RST_DRIVE;
    rd_nxt   = rd_r;
    rbit_nxt = rbit_r;
    hit_nxt  = 1'b0;
    // Bit accesses only reach the three latches; a bit address elsewhere is ignored.
    if (sfr_bit) begin
      if (li >= 0) begin
        hit_nxt = sfr_wr | sfr_rd;
        if (sfr_wr) begin
          latch_nxt[li][bp] = sfr_bit_val;
        end
        if (sfr_rd) begin
          // Bit instructions that write back must see the latch, plain bit tests see the pin.
          rbit_nxt = sfr_rmw ? latch_r[li][bp] : pinval[li][bp];
        end
      end
    end else if (sfr_wr || sfr_rd) begin
      hit_nxt = 1'b1;
      if (li >= 0) begin
        if (sfr_wr) latch_nxt[li] = sfr_wdata;
        if (sfr_rd) rd_nxt = sfr_rmw ? latch_r[li] : pinval[li];
      end else if (sfr_addr == PLMS_ADDR_P1_DRIVE) begin
        if (sfr_wr) drive_nxt[0] = sfr_wdata;
        if (sfr_rd) rd_nxt = drive_r[0];
      end else if (sfr_addr == PLMS_ADDR_P2_DRIVE) begin
        if (sfr_wr) drive_nxt[1] = sfr_wdata;
        if (sfr_rd) rd_nxt = drive_r[1];
      end else if (sfr_addr == PLMS_ADDR_P1_ANADIG) begin
        if (sfr_wr) anadig_nxt[0] = sfr_wdata;
        if (sfr_rd) rd_nxt = anadig_r[0];
      end else if (sfr_addr == PLMS_ADDR_P2_ANADIG) begin
        if (sfr_wr) anadig_nxt[1] = sfr_wdata;
        if (sfr_rd) rd_nxt = anadig_r[1];
      end else if (sfr_addr == PLMS_ADDR_P3_ANADIG) begin
        if (sfr_wr) anadig_nxt[2] = sfr_wdata;
        if (sfr_rd) rd_nxt = anadig_r[2];
      end else if (sfr_addr == PLMS_ADDR_P0_BYPASS) begin
        if (sfr_wr) bypass_nxt[0] = sfr_wdata;
        if (sfr_rd) rd_nxt = bypass_r[0];
      end else if (sfr_addr == PLMS_ADDR_P1_BYPASS) begin
        if (sfr_wr) bypass_nxt[1] = sfr_wdata;
        if (sfr_rd) rd_nxt = bypass_r[1];
      end else if (sfr_addr == PLMS_ADDR_P2_BYPASS) begin
        if (sfr_wr) bypass_nxt[2] = sfr_wdata;
        if (sfr_rd) rd_nxt = bypass_r[2];
      end else begin
        // Unmapped addresses belong to other blocks: nothing changes and no hit is flagged.
        hit_nxt = 1'b0;
      end
    end
  end

  // Configuration group: latches, drive and analog selects and bypass masks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < PLMS_NPORT; k++) begin
        latch_r[k]  <= PLMS_RST_LATCH;
        drive_r[k]  <= PLMS_RST_DRIVE;
        anadig_r[k] <= PLMS_RST_ANADIG;
        bypass_r[k] <= PLMS_RST_BYPASS;
      end
    end else if (ce) begin
      for (int k = 0; k < PLMS_NPORT; k++) begin
        latch_r[k]  <= latch_nxt[k];
        drive_r[k]  <= drive_nxt[k];
        anadig_r[k] <= anadig_nxt[k];
        bypass_r[k] <= bypass_nxt[k];
      end
    end
  end

  // Response group: read data and bit data hold until the next read of their kind, hit lasts one cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r   <= 8'h00;
      rbit_r <= 1'b0;
      hit_r  <= 1'b0;
    end else if (ce) begin
      rd_r   <= rd_nxt;
      rbit_r <= rbit_nxt;
      hit_r  <= hit_nxt;
    end
  end

  // Pad controls are registered so every output leaves a flop; a latch write reaches the pin one cycle late.
  always_comb begin
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
    out_nxt   = out_c;
    oe_nxt    = oe_c;
    skip_nxt  = {bypass_r[2], bypass_r[1], bypass_r[0]};
  end

  // The synchronisers freeze with the rest while ce is low, so a pin change waits for the clock enable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      out_r   <= {PLMS_NPORT{PLMS_RST_LATCH}};
      oe_r    <= 24'h000000;
      skip_r  <= {PLMS_NPORT{PLMS_RST_BYPASS}};
    end else if (ce) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      out_r   <= out_nxt;
      oe_r    <= oe_nxt;
      skip_r  <= skip_nxt;
    end
  end

  // Every output is a flop output; no logic sits between the registers and the ports.
  assign sfr_rdata = rd_r;
  assign sfr_rbit  = rbit_r;
  assign sfr_hit   = hit_r;
  assign pin_out   = out_r;
  assign pin_oe    = oe_r;
  assign skip_mask = skip_r;
endmodule

// *** tb/plms_props.sv ***
// Concurrent checks on the ports of the port latch, mode and bypass block.
`timescale 1ns/1ps
module plms_props (
  input logic                 clk,         // Clock
  input logic                 rst_n,       // Reset
  input logic                 ce,          // Enable
  input logic [7:0]           sfr_addr,    // Address
  input logic                 sfr_wr,      // Write
  input logic                 sfr_rd,      // Read
  input logic                 sfr_rmw,     // Latch read
  input logic                 sfr_bit,     // Bit access
  input logic                 sfr_bit_val, // Bit value
  input plms_pkg::plms_byte_t sfr_wdata,   // Wdata
  input plms_pkg::plms_byte_t sfr_rdata,   // Rdata
  input logic [23:0]          pin_in,      // Pads in
  input logic [23:0]          pin_out,     // Pads out
  input logic [23:0]          pin_oe,      // Enables
  input logic [23:0]          skip_mask    // Masks
);
  import plms_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic bw, br;
  logic [2:0] bpos;
  logic [7:0] p1;
  assign bw = ce & sfr_wr & ~sfr_bit;
  assign br = ce & sfr_rd & ~sfr_bit;
  assign bpos = sfr_addr[2:0];
  assign p1 = pin_in[7:0];
  sequence pins_quiet; $stable(p1)[*3]; endsequence
  sequence p3_bit_wr; ce && sfr_wr && sfr_bit && sfr_addr[7:3] == 5'h16; endsequence
  skip0_write_a: assert property (bw && sfr_addr == PLMS_ADDR_P0_BYPASS
    |-> ##2 skip_mask[7:0] == $past(sfr_wdata, 2)) else $error("port0 mask wrong");
  skip1_write_a: assert property (bw && sfr_addr == PLMS_ADDR_P1_BYPASS
    |-> ##2 skip_mask[15:8] == $past(sfr_wdata, 2)) else $error("port1 mask wrong");
  skip2_write_a: assert property (bw && sfr_addr == PLMS_ADDR_P2_BYPASS
    |-> ##2 skip_mask[23:16] == $past(sfr_wdata, 2)) else $error("port2 mask wrong");
  reset_idle_a: assert property ($rose(rst_n)
    |-> pin_oe == 24'h000000 && skip_mask == 24'h000000) else $error("reset state wrong");
  latch_drive_a: assert property (bw && sfr_addr == PLMS_ADDR_P1_LATCH
    |-> ##2 pin_out[7:0] == $past(sfr_wdata, 2)) else $error("pad level wrong");
  rmw_latch_a: assert property (br && sfr_rmw && sfr_addr == PLMS_ADDR_P1_LATCH
    |=> sfr_rdata == pin_out[7:0]) else $error("latch read wrong");
  pin_read_a: assert property (pins_quiet ##0 (br && !sfr_rmw && sfr_addr == PLMS_ADDR_P1_LATCH)
    |=> (sfr_rdata & ~$past(p1)) == 8'h00) else $error("pin read wrong");
  bit_write_a: assert property (p3_bit_wr
    |-> ##2 pin_out[16 + $past(bpos, 2)] == $past(sfr_bit_val, 2)) else $error("bit write wrong");
endmodule

// *** tb/plms_pads.sv ***
// Board model: an undriven pad shows the board level, a driven one the block's level.
`timescale 1ns/1ps
module plms_pads (
  input  logic [23:0] pin_out, // Block level
  input  logic [23:0] pin_oe,  // Block enable
  input  logic [23:0] ext,     // Board level
  output logic [23:0] pin_in   // Pad level
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// *** tb/test_plms_top.sv ***
// Testbench for the port latch, mode and bypass block.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t %h %h", $time, a, b); end end
module test_plms_top;
  import plms_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, rmw = 1'b0, bt = 1'b0, bv = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  plms_byte_t rdata;
  logic rbit, hit;
  logic [23:0] ext = 24'hFFFFFF, pin_in, pin_out, pin_oe, skip_mask;
  int err_count = 0, n_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  plms_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_rmw(rmw),
    .sfr_bit(bt), .sfr_bit_val(bv), .sfr_wdata(wd), .sfr_rdata(rdata), .sfr_rbit(rbit), .sfr_hit(hit),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .skip_mask(skip_mask));
  plms_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  task wrap_up;
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task acc(input logic [7:0] a, input logic w, input logic m, input logic b, input logic [7:0] d);
    @(posedge clk);
    #1;
    {addr, wr, rd, rmw, bt, bv, wd} = {a, w, ~w, m, b, d[0], d};
    @(posedge clk);
    #1;
    {wr, rd} = 2'b00;
  endtask
  task rdchk(input logic [7:0] a, input logic m, input logic [7:0] e);
    acc(a, 1'b0, m, 1'b0, 8'h00);
    `CHK(rdata, e)
  endtask
  task bitchk(input logic [7:0] a, input logic m, input logic e);
    acc(a, 1'b0, m, 1'b1, 8'h00);
    `CHK(rbit, e)
  endtask
  // Three edges cover the pad register lag plus the two-stage input synchroniser.
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // The whole sequence needs about a hundred cycles; a hang is cut well past that.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    `CHK({skip_mask, pin_oe, pin_out}, 72'h000000_000000_FFFFFF)
    acc(PLMS_ADDR_P0_BYPASS, 1'b1, 1'b0, 1'b0, 8'hA5);
    `CHK(hit, 1'b1)
    acc(PLMS_ADDR_P1_BYPASS, 1'b1, 1'b0, 1'b0, 8'h5A);
    acc(PLMS_ADDR_P2_BYPASS, 1'b1, 1'b0, 1'b0, 8'hF0);
    rdchk(PLMS_ADDR_P1_BYPASS, 1'b0, 8'h5A);
    `CHK(skip_mask, 24'hF05AA5)
    acc(PLMS_ADDR_P2_LATCH, 1'b1, 1'b0, 1'b0, 8'h0F);
    acc(PLMS_ADDR_P2_DRIVE, 1'b1, 1'b0, 1'b0, 8'h03);
    settle;
    `CHK({pin_out[15:8], pin_oe[15:8]}, 16'h0FF3)
    // Upper port 2 pins become analog, matching the bypass set above.
    acc(PLMS_ADDR_P2_ANADIG, 1'b1, 1'b0, 1'b0, 8'h0F);
    settle;
    `CHK(pin_oe[15:8], 8'h03)
    rdchk(PLMS_ADDR_P2_LATCH, 1'b0, 8'h0F);
    ext = 24'hFF0000;
    settle;
    rdchk(PLMS_ADDR_P2_LATCH, 1'b0, 8'h03);
    rdchk(PLMS_ADDR_P2_LATCH, 1'b1, 8'h0F);
    bitchk(8'hA1, 1'b0, 1'b1);
    `CHK(hit, 1'b1)
    bitchk(8'hA2, 1'b0, 1'b0);
    bitchk(8'hA2, 1'b1, 1'b1);
    acc(PLMS_ADDR_P1_LATCH, 1'b1, 1'b0, 1'b0, 8'h55);
    settle;
    `CHK(pin_oe[7:0], 8'hAA)
    rdchk(PLMS_ADDR_P1_LATCH, 1'b0, 8'h00);
    acc(8'h93, 1'b1, 1'b0, 1'b1, 8'h01);
    acc(8'hB3, 1'b1, 1'b0, 1'b1, 8'h00);
    settle;
    `CHK({pin_out, pin_oe[23:16]}, 32'hF70F5D_08)
    rdchk(PLMS_ADDR_P1_LATCH, 1'b1, 8'h5D);
    rdchk(PLMS_ADDR_P1_DRIVE, 1'b0, PLMS_RST_DRIVE);
    rdchk(PLMS_ADDR_P1_ANADIG, 1'b0, 8'hFF);
    rdchk(PLMS_ADDR_P0_BYPASS, 1'b0, 8'hA5);
    rdchk(PLMS_ADDR_P2_BYPASS, 1'b0, 8'hF0);
    acc(PLMS_ADDR_P1_DRIVE, 1'b1, 1'b0, 1'b0, 8'hFF);
    acc(PLMS_ADDR_P1_ANADIG, 1'b1, 1'b0, 1'b0, 8'hF0);
    acc(PLMS_ADDR_P3_ANADIG, 1'b1, 1'b0, 1'b0, 8'hF7);
    settle;
    `CHK({pin_oe[23:16], pin_oe[7:0]}, 16'h00F0)
    rdchk(PLMS_ADDR_P1_LATCH, 1'b0, 8'h50);
    rdchk(PLMS_ADDR_P3_ANADIG, 1'b0, 8'hF7);
    // Unmapped addresses and bit accesses outside the latches are left alone.
    acc(8'hC0, 1'b1, 1'b0, 1'b0, 8'h3C);
    `CHK(hit, 1'b0)
    acc(8'hD1, 1'b1, 1'b0, 1'b1, 8'h01);
    `CHK(hit, 1'b0)
    rdchk(8'hC0, 1'b0, 8'hF7);
    // A write while the clock enable is low must not land.
    ce = 1'b0;
    acc(PLMS_ADDR_P0_BYPASS, 1'b1, 1'b0, 1'b0, 8'h00);
    ce = 1'b1;
    rdchk(PLMS_ADDR_P0_BYPASS, 1'b0, 8'hA5);
    `CHK(skip_mask, 24'hF05AA5)
    wrap_up;
  end
endmodule
bind plms_top plms_props u_props (.clk(clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_bit(sfr_bit), .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .skip_mask(skip_mask));
